// >>> rtl/spi_eeprom_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM front end
// Assumes: 250 MHz system clock sampling all serial pins
// Notes:   Status bit positions, opcodes and programming time live here
package spi_eeprom_pkg;
    // Opcodes
    localparam logic [7:0] OP_SET_WE  = 8'h06;
    localparam logic [7:0] OP_CLR_WE  = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_WRITE   = 8'h02;
    // Status/control bit positions
    localparam int BIT_PPE  = 7;
    localparam int BIT_IPS  = 6;
    localparam int BIT_LOCK = 4;
    localparam int BIT_BPH  = 3;
    localparam int BIT_BPL  = 2;
    // Non-volatile reset values
    localparam logic       PPE_RST  = 1'b0;
    localparam logic       LOCK_RST = 1'b0;
    localparam logic [1:0] BP_RST   = 2'b00;
    // Block-protect encodings and boundaries
    localparam logic [1:0]  BP_QTR    = 2'b01;
    localparam logic [1:0]  BP_HALF   = 2'b10;
    localparam logic [1:0]  BP_FULL   = 2'b11;
    localparam logic [16:0] QTR_BASE  = 17'h1_8000;
    localparam logic [16:0] HALF_BASE = 17'h1_0000;
    // Widths and sequence points
    localparam int         MEM_AW        = 17;
    localparam int         PAGE_AW       = 8;
    localparam logic [4:0] LAST_BIT      = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
    // Programming cycle time
    localparam int PROG_TIME_MS = 5;
    localparam int CLK_KHZ      = 250000;
    localparam int PROG_CYCLES  = PROG_TIME_MS * CLK_KHZ;
    // Sampled pin group
    typedef struct packed {
        logic csN;
        logic sck;
        logic si;
        logic holdN;
        logic wpN;
    } spi_pins_t;
    localparam spi_pins_t PINS_IDLE = 5'h13;
    typedef enum logic [7:0] {
        ST_CMD    = 8'b0000_0001,
        ST_RADDR  = 8'b0000_0010,
        ST_WADDR  = 8'b0000_0100,
        ST_WDATA  = 8'b0000_1000,
        ST_SDATA  = 8'b0001_0000,
        ST_RDATA  = 8'b0010_0000,
        ST_RSTAT  = 8'b0100_0000,
        ST_IGNORE = 8'b1000_0000
    } phase_t;
endpackage : spi_eeprom_pkg

// >>> rtl/spi_eeprom_command_protect.sv
// Purpose: SPI slave front end of a serial EEPROM with status and protection
// Assumes: Pins are asynchronous and pass a two-stage synchroniser
// Notes:   Serial clock must stay well below a quarter of clk
//
// Overview of operation
// - Sample serial input on shift-clock rise
// - Change serial output on shift-clock fall
// - Deselected: output floats, standby unless busy
// - Capture opcode, ignore undefined values
// - Decode memory read and write opcodes
// - Status register bit layout fixed
// - Busy reflects programming, host cannot write
// - Latch set and cleared by commands
// - Block-protect written only by status write
// - Block-protect selects protected address range
// - Pin protection blocks status writes
// - Write permission follows latch and protection
// - Page select steers access to ID page
// - Page select clears after read/write
// - Page lock makes ID page read-only
// - Setting select and lock together ignored
// - Powers up write disabled
// - Byte write uses low 17 address bits
// - Programming starts on rise; busy ignores all commands but status read
// - Paused: output floats, input ignored
// - Programming end clears write latch
// - Status write alters bits 7,6,4,3,2
// - Read pointer advances after each byte
`timescale 1ns/1ns
module spi_eeprom_command_protect
    import spi_eeprom_pkg::*;
#(
    parameter int PROG_COUNT = PROG_CYCLES
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Serial pins
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic holdN,
    input  wire logic wpN,
    output logic      so,
    output logic      soOe,
    // Power state
    output logic      standby
);
    localparam int            CW       = $clog2(PROG_COUNT + 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(PROG_COUNT - 1);

    spi_pins_t                pinsRaw;
    spi_pins_t                pinsMeta;
    spi_pins_t                pins;
    spi_pins_t                pinsPrev;
    phase_t                   phase;
    phase_t                   cmdPhase;
    logic [4:0]               bitCnt;
    logic [23:0]              shiftIn;
    logic [23:0]              nextShift;
    logic [16:0]              addr;
    logic [2:0]               outCnt;
    logic                     soDrive;
    logic                     gotByte;
    logic                     armWe;
    logic                     armSt;
    logic [7:0]               stVal;
    logic                     statPpe;
    logic                     statIps;
    logic                     statLock;
    logic [1:0]               statBp;
    logic                     statWel;
    logic                     busy;
    logic [CW-1:0]            progCnt;
    logic                     commitIp;
    logic [(1<<PAGE_AW)-1:0]  loaded;
    logic [7:0]               pageBuf [0:(1<<PAGE_AW)-1];
    logic [7:0]               mem     [0:(1<<MEM_AW)-1];
    logic [7:0]               idMem   [0:(1<<PAGE_AW)-1];

    // Synchroniser and edge detection
    assign pinsRaw = {csN, sck, si, holdN, wpN};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinsMeta <= PINS_IDLE;
            pins     <= PINS_IDLE;
            pinsPrev <= PINS_IDLE;
        end else begin
            pinsMeta <= pinsRaw;
            pins     <= pinsMeta;
            pinsPrev <= pins;
        end
    end

    // Edges during hold are dropped, so a pause freezes the sequence
    wire live    = ~pins.csN & pins.holdN;
    wire sckRise = live & pins.sck & ~pinsPrev.sck;
    wire sckFall = live & ~pins.sck & pinsPrev.sck;
    wire csRise  = pins.csN & ~pinsPrev.csN;
    assign nextShift = {shiftIn[22:0], pins.si};
    wire [7:0] opcode = nextShift[7:0];

    // Sequence points
    wire inAddr    = (phase == ST_RADDR) | (phase == ST_WADDR);
    wire cmdDone   = sckRise & (phase == ST_CMD) & (bitCnt == LAST_BIT);
    wire addrDone  = sckRise & inAddr & (bitCnt == LAST_ADDR_BIT);
    wire wByteDone = sckRise & (phase == ST_WDATA) & (bitCnt == LAST_BIT);
    wire sByteDone = sckRise & (phase == ST_SDATA) & (bitCnt == LAST_BIT);
    wire reading   = (phase == ST_RDATA) | (phase == ST_RSTAT);
    wire byteOut   = sckFall & (phase == ST_RDATA) & (outCnt == 3'h7);
    wire memOp     = inAddr | (phase == ST_WDATA) | (phase == ST_RDATA);

    // Only the status read gets through while programming
    wire cmdOk = ~busy | (opcode == OP_STAT_RD);
    assign cmdPhase = ~cmdOk                  ? ST_IGNORE :
                      (opcode == OP_READ)     ? ST_RADDR  :
                      (opcode == OP_WRITE)    ? ST_WADDR  :
                      (opcode == OP_STAT_WR)  ? ST_SDATA  :
                      (opcode == OP_STAT_RD)  ? ST_RSTAT  :
                      ST_IGNORE;

    // Protection
    wire hwProt = ~pins.wpN & statPpe;
    wire mainProt = (statBp == BP_FULL) |
                    ((statBp == BP_HALF) & (addr >= HALF_BASE)) |
                    ((statBp == BP_QTR) & (addr >= QTR_BASE));
    wire ipBlock = statLock | (statBp == BP_FULL);
    wire wrAligned = (phase == ST_WDATA) & (bitCnt == 5'h00) & gotByte;
    wire writeOk = csRise & wrAligned & statWel &
                   (statIps ? ~ipBlock : ~mainProt);
    wire statOk = csRise & armSt & statWel & ~hwProt;
    wire progStart = writeOk | statOk;
    wire progDone = busy & (progCnt == LAST_CNT);
    wire [7:0] idx = progCnt[7:0];
    wire inCommit = ~|progCnt[CW-1:PAGE_AW];
    wire commitNow = busy & inCommit & loaded[idx];
    wire abortWr = csRise & ~writeOk;

    // Phase and bit counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase  <= ST_CMD;
            bitCnt <= 5'h00;
        end else if (pins.csN) begin
            phase  <= ST_CMD;
            bitCnt <= 5'h00;
        end else if (sckRise) begin
            case (phase)
                ST_CMD: begin
                    phase  <= (bitCnt == LAST_BIT) ? cmdPhase : ST_CMD;
                    bitCnt <= (bitCnt == LAST_BIT) ? 5'h00 : bitCnt + 5'h01;
                end
                ST_RADDR, ST_WADDR: begin
                    if (bitCnt == LAST_ADDR_BIT) begin
                        phase  <= (phase == ST_RADDR) ? ST_RDATA : ST_WDATA;
                        bitCnt <= 5'h00;
                    end else begin
                        bitCnt <= bitCnt + 5'h01;
                    end
                end
                ST_WDATA: begin
                    bitCnt <= (bitCnt == LAST_BIT) ? 5'h00 : bitCnt + 5'h01;
                end
                ST_SDATA: begin
                    phase  <= (bitCnt == LAST_BIT) ? ST_IGNORE : ST_SDATA;
                    bitCnt <= bitCnt + 5'h01;
                end
                default: begin
                    phase <= phase;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shiftIn <= 24'h00_0000;
        end else if (sckRise) begin
            shiftIn <= nextShift;
        end
    end

    // Address pointer; only the low 17 address bits are kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr <= 17'h0_0000;
        end else if (addrDone) begin
            addr <= nextShift[16:0];
        end else if (wByteDone | (byteOut & statIps)) begin
            addr <= {addr[16:8], addr[7:0] + 8'h01};
        end else if (byteOut) begin
            addr <= addr + 17'h0_0001;
        end
    end

    // Arming: the latch and status write act only on a clean deselect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armWe   <= 1'b0;
            armSt   <= 1'b0;
            gotByte <= 1'b0;
            stVal   <= 8'h00;
        end else if (pins.csN) begin
            armWe   <= 1'b0;
            armSt   <= 1'b0;
            gotByte <= 1'b0;
        end else if (sckRise) begin
            armWe   <= cmdDone & (opcode == OP_SET_WE) & ~busy;
            armSt   <= sByteDone;
            gotByte <= gotByte | wByteDone;
            stVal   <= sByteDone ? opcode : stVal;
        end
    end

    // Status and control bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statWel  <= 1'b0;
            statPpe  <= PPE_RST;
            statIps  <= 1'b0;
            statLock <= LOCK_RST;
            statBp   <= BP_RST;
        end else begin
            if (progDone) begin
                statWel <= 1'b0;
            end else if (csRise & armWe) begin
                statWel <= 1'b1;
            end else if (cmdDone & (opcode == OP_CLR_WE) & ~busy) begin
                statWel <= 1'b0;
            end
            if (statOk) begin
                statPpe <= stVal[BIT_PPE];
                statBp  <= stVal[BIT_BPH:BIT_BPL];
                if (~(stVal[BIT_IPS] & stVal[BIT_LOCK])) begin
                    statIps  <= stVal[BIT_IPS];
                    statLock <= statLock | stVal[BIT_LOCK];
                end
            end else if (csRise & memOp) begin
                statIps <= 1'b0;
            end
        end
    end

    // Programming cycle timer; busy is never host-writable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy     <= 1'b0;
            progCnt  <= '0;
            commitIp <= 1'b0;
        end else if (progStart) begin
            busy     <= 1'b1;
            progCnt  <= '0;
            commitIp <= statIps;
        end else if (busy) begin
            busy     <= ~progDone;
            progCnt  <= progDone ? progCnt : progCnt + CW'(1);
        end
    end

    // Loaded-byte flags, one per page entry
    genvar i;
    generate
        for (i = 0; i < (1 << PAGE_AW); i++) begin : gLoaded
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    loaded[i] <= 1'b0;
                end else if (wByteDone & (addr[7:0] == 8'(i))) begin
                    loaded[i] <= 1'b1;
                end else if (abortWr | (commitNow & (idx == 8'(i)))) begin
                    loaded[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Page buffer and cell arrays; commit drains one byte per clock
    always_ff @(posedge clk) begin
        if (wByteDone) begin
            pageBuf[addr[7:0]] <= opcode;
        end
        if (commitNow & commitIp) begin
            idMem[idx] <= pageBuf[idx];
        end else if (commitNow) begin
            mem[{addr[16:8], idx}] <= pageBuf[idx];
        end
    end

    // Read path
    wire [7:0] statusByte = {statPpe, statIps, 1'b0, statLock,
                             statBp, statWel, busy};
    wire [7:0] rdByte = (phase == ST_RSTAT) ? statusByte :
                        statIps ? idMem[addr[7:0]] : mem[addr];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            so      <= 1'b0;
            soDrive <= 1'b0;
            outCnt  <= 3'h0;
        end else if (pins.csN) begin
            soDrive <= 1'b0;
            outCnt  <= 3'h0;
        end else if (sckFall & reading) begin
            so      <= rdByte[~outCnt];
            soDrive <= 1'b1;
            outCnt  <= outCnt + 3'h1;
        end
    end

    // Enable drops at once on deselect or pause, so no stale bit is driven
    assign soOe    = soDrive & live;
    assign standby = pins.csN & ~busy;
endmodule : spi_eeprom_command_protect

// >>> verification/spi_eeprom_monitor.sv
// Purpose: Port checker for the EEPROM front end
// Assumes: Pin edges at least 4 clk apart
// Notes:   Busy window is seen through standby
`timescale 1ns/1ns
module spi_eeprom_monitor #(
    parameter int PROG_COUNT = 1000
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic so,
    input wire logic soOe,
    // Power state
    input wire logic standby
);
    logic [3:0] rises;
    logic       sckQ;
    logic       stbQ;
    logic       armed;
    int         busyCnt;
    // Standby falling while deselected marks a programming start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckQ    <= 1'b0;
            stbQ    <= 1'b1;
            rises   <= 4'h0;
            armed   <= 1'b0;
            busyCnt <= 0;
        end else begin
            sckQ    <= sck;
            stbQ    <= standby;
            rises   <= csN ? 4'h0 : rises + 4'(sck && !sckQ && rises != 4'h8);
            armed   <= standby ? 1'b0 : (armed || (stbQ && csN));
            busyCnt <= armed ? busyCnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_deselect_float: assert property (csN [*4] |-> !soOe) else $error("output driven while deselected");
    a_deselect_drop: assert property ($rose(csN) |-> ##[1:4] !soOe) else $error("output kept after deselect");
    a_pause_float: assert property (!holdN [*4] |-> !soOe) else $error("output driven while paused");
    a_no_early_drive: assert property ($rose(soOe) |-> rises == 4'h8) else $error("output before opcode");
    a_so_on_fall: assert property (soOe && $changed(so) |-> !sck) else $error("output moved with clock high");
    a_so_hold_rise: assert property ($rose(sck) && soOe |=> $stable(so) [*3]) else $error("output moved at rise");
    a_select_wakes: assert property (!csN [*4] |-> !standby) else $error("standby while selected");
    a_busy_length: assert property ($rose(standby) && armed |-> busyCnt >= PROG_COUNT - 3 && busyCnt <= PROG_COUNT + 3)
        else $error("busy window length wrong");
    a_busy_bound: assert property (armed |-> busyCnt <= PROG_COUNT + 3) else $error("busy window overran");
    c_drive: cover property ($rose(soOe));
    c_busy_done: cover property ($rose(standby) && armed);
    c_pause: cover property (!holdN && !csN);
endmodule : spi_eeprom_monitor

bind spi_eeprom_command_protect spi_eeprom_monitor #(.PROG_COUNT(PROG_COUNT)) spi_eeprom_monitor_inst (
    .clk(clk), .rst(rst), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN),
    .so(so), .soOe(soOe), .standby(standby));

// >>> verification/spi_host_model.sv
// Purpose: Host controller model in clock mode 0
// Assumes: Bench calls one task at a time
// Notes:   Shift clock stands low between frames
`timescale 1ns/1ns
module spi_host_model (
    // Clock
    input  wire logic       clk,
    // Device pins
    input  wire logic       so,
    input  wire logic       soOe,
    output logic            csN     = 1'b1,
    output logic            sck     = 1'b0,
    output logic            si      = 1'b0,
    output logic            holdN   = 1'b1,
    // Received bytes
    output logic [7:0]      rxByte  = 8'h00,
    output logic            rxValid = 1'b0
);
    localparam int HALF = 20;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic beginFrame();
        tick(1);
        csN <= 1'b0;
        tick(HALF);
    endtask : beginFrame
    task automatic endFrame();
        tick(HALF);
        csN <= 1'b1;
        si  <= ~si;
        tick(8);
    endtask : endFrame
    // Undriven output reads as unknown so it can never match
    task automatic xfer(input logic [7:0] tx, input bit keep);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            tick(HALF);
            sck <= 1'b1;
            rx[i] = (soOe === 1'b1) ? so : 1'bx;
            tick(HALF);
            sck <= 1'b0;
        end
        rxByte  <= rx;
        rxValid <= keep;
        tick(1);
        rxValid <= 1'b0;
    endtask : xfer
    task automatic pause(output logic oe);
        tick(HALF);
        holdN <= 1'b0;
        repeat (HALF) begin
            tick(1);
            si <= ~si;
        end
        oe = soOe;
        holdN <= 1'b1;
        tick(HALF);
    endtask : pause
endmodule : spi_host_model

// >>> verification/test_spi_eeprom_command_protect.sv
// Purpose: Self-checking bench for the EEPROM front end
// Assumes: Short programming count keeps the run small
// Notes:   Read bytes are queued as expectations
`timescale 1ns/1ns
module test_spi_eeprom_command_protect;
    import spi_eeprom_pkg::*;
    localparam int PC = 1000;
    logic        clk;
    logic        rst;
    logic        wpN;
    logic        csN, sck, si, holdN, so, soOe, standby, rxValid;
    logic [7:0]  rxByte;
    logic [7:0]  expQ[$];
    logic [7:0]  d[3];
    logic [16:0] lim[4] = '{17'h1_FFFF, 17'h1_8000, 17'h1_0000, 17'h0_0000};
    int          bad_count = 0;
    int          num_checks = 0;
    spi_eeprom_command_protect #(.PROG_COUNT(PC)) spi_eeprom_command_protect_inst (.clk(clk), .rst(rst),
        .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe), .standby(standby));
    spi_host_model spi_host_model_inst (.clk(clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si),
        .holdN(holdN), .rxByte(rxByte), .rxValid(rxValid));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) if (rxValid === 1'b1) check(rxByte, expQ.size() > 0 ? expQ.pop_front() : ~rxByte);
    task automatic waitIdle();
        int n = 0;
        while (standby !== 1'b1 && n < 3 * PC) begin
            @(posedge clk);
            n++;
        end
        if (n == 3 * PC) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : waitIdle
    task automatic sendOp(input logic [7:0] op);
        spi_host_model_inst.beginFrame();
        spi_host_model_inst.xfer(op, 1'b0);
        spi_host_model_inst.endFrame();
    endtask : sendOp
    task automatic statusIs(input logic [7:0] e);
        expQ.push_back(e);
        spi_host_model_inst.beginFrame();
        spi_host_model_inst.xfer(OP_STAT_RD, 1'b0);
        spi_host_model_inst.xfer(8'h00, 1'b1);
        spi_host_model_inst.endFrame();
    endtask : statusIs
    task automatic statusWrite(input logic [7:0] v);
        sendOp(OP_SET_WE);
        spi_host_model_inst.beginFrame();
        spi_host_model_inst.xfer(OP_STAT_WR, 1'b0);
        spi_host_model_inst.xfer(v, 1'b0);
        spi_host_model_inst.endFrame();
        waitIdle();
    endtask : statusWrite
    task automatic addrFrame(input logic [7:0] op, input logic [23:0] a);
        spi_host_model_inst.beginFrame();
        spi_host_model_inst.xfer(op, 1'b0);
        for (int i = 2; i >= 0; i--) spi_host_model_inst.xfer(a[8*i+:8], 1'b0);
    endtask : addrFrame
    task automatic memWrite(input logic [23:0] a, input logic [7:0] dt, input bit we, input bit acc, input bit idle);
        if (we) sendOp(OP_SET_WE);
        addrFrame(OP_WRITE, a);
        spi_host_model_inst.xfer(dt, 1'b0);
        spi_host_model_inst.endFrame();
        check({7'h00, standby}, {7'h00, !acc});
        if (idle) waitIdle();
    endtask : memWrite
    task automatic memRead(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1, input bit two);
        logic oe;
        expQ.push_back(e0);
        if (two) expQ.push_back(e1);
        addrFrame(OP_READ, a);
        spi_host_model_inst.xfer(8'h00, 1'b1);
        if (two) begin
            spi_host_model_inst.pause(oe);
            check({7'h00, oe}, 8'h00);
            spi_host_model_inst.xfer(8'h00, 1'b1);
        end
        spi_host_model_inst.endFrame();
    endtask : memRead
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        wpN = 1'b1;
        void'($urandom(87457));
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        statusIs(8'h00);
        addrFrame(8'h55, 24'h00_0000);
        check({7'h00, soOe}, 8'h00);
        spi_host_model_inst.endFrame();
        sendOp(OP_SET_WE);
        statusIs(8'h02);
        sendOp(OP_CLR_WE);
        statusIs(8'h00);
        addrFrame(OP_SET_WE, 24'h00_0000);
        spi_host_model_inst.endFrame();
        statusIs(8'h00);
        memWrite(24'hFE_0010, d[0], 1'b1, 1'b1, 1'b0);
        statusIs(8'h03);
        waitIdle();
        statusIs(8'h00);
        memWrite(24'h00_0011, d[1], 1'b1, 1'b1, 1'b1);
        memWrite(24'h00_0010, d[2], 1'b0, 1'b0, 1'b1);
        memRead(24'h80_0010, d[0], d[1], 1'b1);
        statusWrite(8'hFF);
        statusIs(8'h8C);
        for (int k = 0; k < 4; k++) begin
            statusWrite(8'(k << 2));
            memWrite({7'h00, lim[k]}, 8'h5A, 1'b1, k == 0, 1'b1);
            if (k == 1 || k == 2) memWrite({7'h00, lim[k] - 17'h1}, 8'hA5, 1'b1, 1'b1, 1'b1);
        end
        statusWrite(8'h80);
        wpN <= 1'b0;
        statusWrite(8'h00);
        statusIs(8'h82);
        wpN <= 1'b1;
        statusWrite(8'h00);
        statusIs(8'h00);
        statusWrite(8'h40);
        statusIs(8'h40);
        memWrite(24'h12_3410, d[2], 1'b1, 1'b1, 1'b1);
        statusIs(8'h00);
        memRead(24'h00_0010, d[0], d[1], 1'b0);
        statusWrite(8'h40);
        memRead(24'h00_0010, d[2], d[1], 1'b0);
        statusWrite(8'h10);
        statusWrite(8'h40);
        statusIs(8'h50);
        memWrite(24'h00_0010, ~d[2], 1'b1, 1'b0, 1'b1);
        statusWrite(8'h40);
        memRead(24'h00_0010, d[2], d[1], 1'b0);
        tally_and_finish();
    end
endmodule : test_spi_eeprom_command_protect
